/* ddr_mode_pkg.sv */
/*
 * Shared constants for the mode register model: link command codes,
 * mode register field positions, reset values and bus offsets.
 * Assumes both link ends and the carrier interface import it.
 */
package ddr_mode_pkg;
    typedef enum logic [2:0] {
        CMD_NOP = 3'h0, CMD_MRS = 3'h1, CMD_ACT = 3'h2, CMD_RD = 3'h3,
        CMD_WR = 3'h4, CMD_REF = 3'h5, CMD_SYNC = 3'h6
    } link_cmd_t;
    localparam int ADDR_W = 14;
    localparam int DATA_W = 8;
    localparam logic [2:0] RESERVED_MR = 3'h7;
    // MR0
    localparam int CL_BASE = 9;
    // MR1
    localparam int MR1_DLL = 0;
    localparam int MR1_DRV = 1;
    localparam int MR1_AL = 3;
    localparam int MR1_WLEV = 7;
    localparam int MR1_NOM = 8;
    localparam int MR1_EXTRA_STROBE_TERMINATION = 11;
    localparam int MR1_QOFF = 12;
    // MR2
    localparam int MR2_CWL = 3;
    localparam int MR2_SRT = 6;
    localparam int MR2_WR = 9;
    localparam int MR2_CRC = 12;
    // MR3
    localparam int MR3_PAGE = 0;
    localparam int MR3_RDOUT = 2;
    localparam int MR3_GEAR = 3;
    localparam int MR3_PDA = 4;
    localparam int MR3_TSR = 5;
    localparam int MR3_WCL = 9;
    // MR4
    localparam int MR4_TCR = 3;
    localparam int MR4_RPT = 10;
    localparam int MR4_RPRE = 11;
    localparam int MR4_WPRE = 12;
    // MR5
    localparam int MR5_PARK = 6;
    localparam int MR5_DM = 10;
    localparam int MR5_WDBI = 11;
    localparam int MR5_RDBI = 12;
    localparam logic [1:0] TEMP_PAGE = 2'h2;
    localparam logic [ADDR_W-1:0] MR_RESET = 14'h0000;
    localparam logic [ADDR_W-1:0] MR1_RESET = 14'h0001;
    localparam int BEATS_PLAIN = 8;
    localparam int BEATS_CRC = 10;
    // Controller registers on Wishbone
    localparam logic [3:0] OFS_CMD = 4'h0;
    localparam logic [3:0] OFS_STATUS = 4'h4;
    localparam logic [3:0] OFS_CFG = 4'h8;
    localparam int LINK_HALF_DIV = 4;
    localparam int CMD_POS = 17;
    localparam int BANK_POS = 14;

    function automatic logic [4:0] cwlDecode(input logic [2:0] code);
        case (code)
            3'h0: cwlDecode = 5'h09;
            3'h1: cwlDecode = 5'h0A;
            3'h2: cwlDecode = 5'h0B;
            3'h3: cwlDecode = 5'h0C;
            3'h4: cwlDecode = 5'h0E;
            3'h5: cwlDecode = 5'h10;
            default: cwlDecode = 5'h12;
        endcase
    endfunction
endpackage

/* ddr_mode_link.sv */
/*
 * Carrier between controller and memory device. Resolves the shared
 * data wires from the output enables of each end, the strobe from the device's alone.
 * Assumes the bench connects both ends through the modports.
 */
`timescale 1ns/10ps
interface ddr_mode_link;
    import ddr_mode_pkg::*;
    logic ck;
    logic csN;
    logic [2:0] cmd;
    logic [2:0] bank;
    logic [ADDR_W-1:0] addr;
    logic termination_control_input;
    logic [DATA_W-1:0] ctlDq;
    logic ctlDqOe;
    logic [DATA_W-1:0] devDq;
    logic devDqOe;
    logic devDqs;
    logic devDqsOe;
    logic [DATA_W-1:0] dq;
    logic dqs;
    // Undriven bus reads as pulled up
    assign dq = devDqOe ? devDq : (ctlDqOe ? ctlDq : {DATA_W{1'b1}});
    assign dqs = devDqsOe ? devDqs : 1'b0;
    modport controller (output ck, csN, cmd, bank, addr, termination_control_input, ctlDq, ctlDqOe,
        input dq, dqs);
    modport device (input ck, csN, cmd, bank, addr, termination_control_input, dq,
        output devDq, devDqOe, devDqs, devDqsOe);
endinterface

/* ddr_mode_device.sv */
/*
 * Memory device end: mode registers MR0..MR6, feature decode, latency
 * sequencing and strobe preamble. All link pins are synchronised to
 * clk_sys, which must run at least eight times the link clock.
 */
`timescale 1ns/10ps
module ddr_mode_device
    import ddr_mode_pkg::*;
(
    input wire logic clk_sys,
    input wire logic arst_n,
    ddr_mode_link.device link,
    input wire logic [1:0] tempStatus,
    input wire logic tempCool,
    input wire logic [DATA_W-1:0] readWord,
    output logic [1:0] driverImpedance,
    output logic outputsOff,
    output logic [2:0] terminationSel,
    output logic [5:0] readLatency,
    output logic [5:0] writeLatency,
    output logic strobeTermOn,
    output logic writeMaskOn,
    output logic writeInvOn,
    output logic readInvOn,
    output logic [3:0] writeBeats,
    output logic tempReportOn,
    output logic quarterRate,
    output logic wrPreambleTwo,
    output logic rdPreambleTwo,
    output logic [1:0] selfRefreshRange,
    output logic internalCmd,
    output logic [DATA_W-1:0] writeWord,
    output logic writeWordValid,
    output logic refreshDone
);
    localparam int IN_W = 1 + 3 + 3 + ADDR_W + 1 + DATA_W;
    typedef enum logic [1:0] {IDLE = 2'b00, WAIT = 2'b01, BURST = 2'b11} seq_t;

    logic [IN_W-1:0] pinS1, pinS2;
    logic ckS1, ckS2, ckS3;
    logic ckRise;
    logic sCsN, sOdt;
    logic [2:0] sCmd, sBank;
    logic [ADDR_W-1:0] sAddr;
    logic [DATA_W-1:0] sDq;
    logic [ADDR_W-1:0] modeReg [0:6];
    logic [4:0] casLat, write_column_latency, addLat;
    logic seqIsRead;
    seq_t state_reg;
    logic [5:0] count_reg;
    logic [3:0] beat_reg;
    logic skip_reg;
    logic writing;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pinS1 <= '0;
            pinS2 <= '0;
            ckS1 <= 1'b0;
            ckS2 <= 1'b0;
            ckS3 <= 1'b0;
        end else begin
            pinS1 <= {link.csN, link.cmd, link.bank, link.addr, link.termination_control_input, link.dq};
            pinS2 <= pinS1;
            ckS1 <= link.ck;
            ckS2 <= ckS1;
            ckS3 <= ckS2;
        end
    end
    assign {sCsN, sCmd, sBank, sAddr, sOdt, sDq} = pinS2;
    assign ckRise = ckS2 & ~ckS3;

    // Latency decode
    assign casLat = 5'(CL_BASE) + {1'b0, modeReg[0][6:4], modeReg[0][2]};
    assign write_column_latency = cwlDecode(modeReg[2][MR2_CWL +: 3]);
    always_comb begin
        case (modeReg[1][MR1_AL +: 2])
            2'h1: addLat = casLat - 5'h01;
            2'h2: addLat = casLat - 5'h02;
            default: addLat = 5'h00;
        endcase
    end

    // Mode register writes
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < 7; i++) begin
                modeReg[i] <= (i == 1) ? MR1_RESET : MR_RESET;
            end
        end else if (ckRise && !sCsN && sCmd == CMD_MRS && sBank != RESERVED_MR) begin
            // Masked device keeps its value when its data line is high
            if (!(modeReg[3][MR3_PDA] && sDq[0])) begin
                modeReg[sBank] <= sAddr;
            end
        end
    end

    // Gear-down: only a sync pulse moves the sampling edge
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            quarterRate <= 1'b0;
        end else if (ckRise && !sCsN && sCmd == CMD_SYNC) begin
            quarterRate <= modeReg[3][MR3_GEAR];
        end
    end

    // Column command sequencer, counted in link clocks
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= IDLE;
            count_reg <= 6'h00;
            beat_reg <= 4'h0;
            seqIsRead <= 1'b0;
            internalCmd <= 1'b0;
        end else begin
            internalCmd <= 1'b0;
            case (state_reg)
                IDLE: begin
                    if (ckRise && !sCsN && (sCmd == CMD_RD || sCmd == CMD_WR)) begin
                        seqIsRead <= (sCmd == CMD_RD);
                        // Total wait is RL or WL; inner command after AL
                        count_reg <= (sCmd == CMD_RD) ? readLatency : writeLatency;
                        state_reg <= WAIT;
                        if (addLat == 5'h00) begin
                            internalCmd <= 1'b1;
                        end
                    end
                end
                WAIT: begin
                    if (ckRise) begin
                        count_reg <= count_reg - 6'h01;
                        if (count_reg - 6'h01 == (seqIsRead ? 6'(casLat) : 6'(write_column_latency))
                                && addLat != 5'h00) begin
                            internalCmd <= 1'b1;
                        end
                        if (count_reg == 6'h01) begin
                            state_reg <= BURST;
                            beat_reg <= seqIsRead ? 4'(BEATS_PLAIN) : writeBeats;
                        end
                    end
                end
                BURST: begin
                    if (ckRise) begin
                        beat_reg <= beat_reg - 4'h1;
                        if (beat_reg == 4'h1) begin
                            state_reg <= IDLE;
                        end
                    end
                end
                default: state_reg <= IDLE;
            endcase
        end
    end
    assign writing = !seqIsRead && state_reg != IDLE;

    // Write data capture; CRC beats are taken but not delivered
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            writeWord <= '0;
            writeWordValid <= 1'b0;
        end else begin
            writeWordValid <= ckRise && state_reg == BURST && !seqIsRead
                && beat_reg > writeBeats - 4'(BEATS_PLAIN);
            if (ckRise && state_reg == BURST && !seqIsRead) begin
                writeWord <= sDq;
            end
        end
    end

    // Read drive with preamble; training keeps the strobe running
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            link.devDq <= '0;
            link.devDqOe <= 1'b0;
            link.devDqs <= 1'b0;
            link.devDqsOe <= 1'b0;
        end else begin
            // Raw bit: the registered flag lags, pins must go quiet with it
            link.devDqOe <= seqIsRead && state_reg == BURST && !modeReg[1][MR1_QOFF];
            link.devDqsOe <= !modeReg[1][MR1_QOFF] && (modeReg[4][MR4_RPT]
                || (seqIsRead && state_reg == BURST)
                || (seqIsRead && state_reg == WAIT
                    && count_reg <= (rdPreambleTwo ? 6'h02 : 6'h01)));
            link.devDqs <= (state_reg == BURST || modeReg[4][MR4_RPT]) ? ckS2 : 1'b0;
            if (modeReg[3][MR3_RDOUT] && modeReg[3][MR3_PAGE +: 2] == TEMP_PAGE) begin
                link.devDq <= {3'h0, tempStatus, 3'h0};
            end else begin
                link.devDq <= readWord;
            end
        end
    end

    // Refresh with temperature-controlled skipping
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            skip_reg <= 1'b0;
            refreshDone <= 1'b0;
        end else begin
            refreshDone <= 1'b0;
            if (ckRise && !sCsN && sCmd == CMD_REF) begin
                if (modeReg[4][MR4_TCR] && modeReg[2][MR2_SRT +: 2] == 2'h3 && tempCool) begin
                    skip_reg <= !skip_reg;
                    refreshDone <= skip_reg;
                end else begin
                    refreshDone <= 1'b1;
                end
            end
        end
    end

    // Feature decode, registered onto the outputs
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            driverImpedance <= 2'h0;
            outputsOff <= 1'b0;
            terminationSel <= 3'h0;
            readLatency <= 6'h00;
            writeLatency <= 6'h00;
            strobeTermOn <= 1'b0;
            writeMaskOn <= 1'b0;
            writeInvOn <= 1'b0;
            readInvOn <= 1'b0;
            writeBeats <= 4'(BEATS_PLAIN);
            tempReportOn <= 1'b0;
            wrPreambleTwo <= 1'b0;
            rdPreambleTwo <= 1'b0;
            selfRefreshRange <= 2'h0;
        end else begin
            driverImpedance <= modeReg[1][MR1_DRV +: 2];
            outputsOff <= modeReg[1][MR1_QOFF];
            if (!sOdt) begin
                terminationSel <= modeReg[5][MR5_PARK +: 3];
            end else if (writing && !modeReg[1][MR1_WLEV]
                    && modeReg[2][MR2_WR +: 3] != 3'h0) begin
                terminationSel <= modeReg[2][MR2_WR +: 3];
            end else begin
                terminationSel <= modeReg[1][MR1_NOM +: 3];
            end
            readLatency <= 6'(addLat) + 6'(casLat);
            writeLatency <= 6'(addLat) + 6'(write_column_latency);
            strobeTermOn <= modeReg[1][MR1_EXTRA_STROBE_TERMINATION];
            writeMaskOn <= modeReg[5][MR5_DM] && !modeReg[1][MR1_EXTRA_STROBE_TERMINATION];
            // Masking wins if both are requested
            writeInvOn <= modeReg[5][MR5_WDBI] && !modeReg[5][MR5_DM]
                && !modeReg[1][MR1_EXTRA_STROBE_TERMINATION];
            readInvOn <= modeReg[5][MR5_RDBI] && !modeReg[1][MR1_EXTRA_STROBE_TERMINATION];
            writeBeats <= modeReg[2][MR2_CRC] ? 4'(BEATS_CRC) : 4'(BEATS_PLAIN);
            tempReportOn <= modeReg[3][MR3_TSR];
            wrPreambleTwo <= modeReg[4][MR4_WPRE];
            rdPreambleTwo <= modeReg[4][MR4_RPRE];
            selfRefreshRange <= modeReg[2][MR2_SRT +: 2];
        end
    end
endmodule

/* ddr_mode_ctrl.sv */
/*
 * Controller end: Wishbone classic slave that launches one link
 * command at a time and derives the link clock by a divider.
 * Assumes the device samples on the link clock rising edge.
 */
`timescale 1ns/10ps
module ddr_mode_ctrl
    import ddr_mode_pkg::*;
#(
    parameter bit IS_X16 = 1'b1
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    ddr_mode_link.controller link
);
    logic [2:0] div_reg;
    logic launch_reg;
    logic busy_reg, refused_reg, odtReq_reg, pdaOff_reg;
    logic [19:0] cmdWord_reg;
    logic [ADDR_W-1:0] mrVal;
    logic [ADDR_W-1:0] shadow1, shadow2, shadow5;
    logic dqsS1, dqsS2;
    logic [DATA_W-1:0] dqS1, dqS2, captured_reg;
    logic fall;
    logic wrStrobe;

    assign fall = link.ck && div_reg == 3'(LINK_HALF_DIV - 1);
    assign wrStrobe = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];

    // Fix up mode values on the way out
    always_comb begin
        mrVal = wb_dat_i[ADDR_W-1:0];
        if (wb_dat_i[BANK_POS +: 3] == 3'h1 && IS_X16) begin
            mrVal[MR1_EXTRA_STROBE_TERMINATION] = 1'b0;
        end
        if (wb_dat_i[BANK_POS +: 3] == 3'h3 && shadow2[MR2_CRC] && shadow5[MR5_DM]
                && mrVal[MR3_WCL +: 2] == 2'h0) begin
            mrVal[MR3_WCL +: 2] = 2'h1;
        end
        if (wb_dat_i[BANK_POS +: 3] == 3'h5 && mrVal[MR5_DM]) begin
            mrVal[MR5_WDBI] = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            div_reg <= 3'h0;
            link.ck <= 1'b0;
        end else if (div_reg == 3'(LINK_HALF_DIV - 1)) begin
            div_reg <= 3'h0;
            link.ck <= !link.ck;
        end else begin
            div_reg <= div_reg + 3'h1;
        end
    end

    // Register bus: answer one cycle after the request
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
            if (wb_adr_i == OFS_CMD) begin
                wb_dat_o <= {12'h000, cmdWord_reg};
            end else if (wb_adr_i == OFS_STATUS) begin
                wb_dat_o <= {22'h0, refused_reg, busy_reg, captured_reg};
            end else if (wb_adr_i == OFS_CFG) begin
                wb_dat_o <= {30'h0, pdaOff_reg, odtReq_reg};
            end else begin
                wb_dat_o <= 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            odtReq_reg <= 1'b0;
            pdaOff_reg <= 1'b0;
        end else if (wrStrobe && wb_adr_i == OFS_CFG) begin
            odtReq_reg <= wb_dat_i[0];
            pdaOff_reg <= wb_dat_i[1];
        end
    end

    // Command intake; reserved mode address and busy writes refused
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cmdWord_reg <= 20'h00000;
            busy_reg <= 1'b0;
            refused_reg <= 1'b0;
            launch_reg <= 1'b0;
            shadow1 <= MR1_RESET;
            shadow2 <= MR_RESET;
            shadow5 <= MR_RESET;
        end else begin
            if (wrStrobe && wb_adr_i == OFS_CMD) begin
                if (busy_reg || (wb_dat_i[CMD_POS +: 3] == CMD_MRS
                        && wb_dat_i[BANK_POS +: 3] == RESERVED_MR)) begin
                    refused_reg <= 1'b1;
                end else begin
                    cmdWord_reg <= {wb_dat_i[CMD_POS +: 3], wb_dat_i[BANK_POS +: 3], mrVal};
                    busy_reg <= 1'b1;
                    if (wb_dat_i[CMD_POS +: 3] == CMD_MRS) begin
                        if (wb_dat_i[BANK_POS +: 3] == 3'h1) shadow1 <= mrVal;
                        if (wb_dat_i[BANK_POS +: 3] == 3'h2) shadow2 <= mrVal;
                        if (wb_dat_i[BANK_POS +: 3] == 3'h5) shadow5 <= mrVal;
                    end
                end
            end else if (wrStrobe && wb_adr_i == OFS_STATUS && wb_dat_i[9]) begin
                refused_reg <= 1'b0;
            end
            if (fall && busy_reg && !launch_reg) begin
                launch_reg <= 1'b1;
            end else if (fall && launch_reg) begin
                launch_reg <= 1'b0;
                busy_reg <= 1'b0;
            end
        end
    end

    // Pins change on the link clock falling edge only
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            link.csN <= 1'b1;
            link.cmd <= CMD_NOP;
            link.bank <= 3'h0;
            link.addr <= '0;
            link.termination_control_input <= 1'b0;
            link.ctlDq <= {DATA_W{1'b1}};
            link.ctlDqOe <= 1'b0;
        end else if (fall) begin
            link.csN <= !(busy_reg && !launch_reg);
            link.cmd <= cmdWord_reg[CMD_POS +: 3];
            link.bank <= cmdWord_reg[BANK_POS +: 3];
            link.addr <= cmdWord_reg[ADDR_W-1:0];
            // No termination request while the DLL is off
            link.termination_control_input <= odtReq_reg && shadow1[MR1_DLL];
            link.ctlDq <= {{(DATA_W-1){1'b1}}, pdaOff_reg};
            link.ctlDqOe <= busy_reg && !launch_reg;
        end
    end

    // Read capture while the device strobe is high
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            dqsS1 <= 1'b0;
            dqsS2 <= 1'b0;
            dqS1 <= '0;
            dqS2 <= '0;
            captured_reg <= '0;
        end else begin
            dqsS1 <= link.dqs;
            dqsS2 <= dqsS1;
            dqS1 <= link.dq;
            dqS2 <= dqS1;
            if (dqsS2) begin
                captured_reg <= dqS2;
            end
        end
    end
endmodule

/* ddr_mode_assertions.sv */
/* Checker on the link between the two ends and the device's feature outputs.
   Assumes the bench instantiates it beside the interface, on clk_sys. */
`timescale 1ns/10ps
module ddr_mode_assertions
    import ddr_mode_pkg::*;
(
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic ck,
    input wire logic csN,
    input wire logic [2:0] cmd,
    input wire logic [2:0] bank,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic ctlDqOe,
    input wire logic devDqOe,
    input wire logic devDqsOe,
    input wire logic outputsOff,
    input wire logic strobeTermOn,
    input wire logic writeMaskOn,
    input wire logic writeInvOn,
    input wire logic readInvOn,
    input wire logic [3:0] writeBeats
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);
    wire mrsOut = !csN && cmd == CMD_MRS;
    ck_high_a: assert property ($rose(ck) |-> ck [*4] ##1 !ck)
        else $error("link clock high phase not four cycles");
    cmd_hold_a: assert property ($fell(csN) |=>
        (!csN && $stable({cmd, bank, addr})) [*7] ##1 csN)
        else $error("command not held one link clock");
    no_reserved_a: assert property (mrsOut |-> bank != RESERVED_MR)
        else $error("mode command sent to reserved register");
    x16_extra_strobe_termination_a: assert property (mrsOut && bank == 3'h1 |-> !addr[MR1_EXTRA_STROBE_TERMINATION])
        else $error("strobe termination sent to x16 part");
    off_quiet_a: assert property (outputsOff |-> !devDqOe && !devDqsOe)
        else $error("device drives while outputs off");
    extra_strobe_termination_excl_a: assert property (strobeTermOn |-> !(writeMaskOn || writeInvOn || readInvOn))
        else $error("masking or inversion with strobe termination");
    mask_excl_a: assert property (!(writeMaskOn && writeInvOn))
        else $error("write mask and write inversion together");
    beats_a: assert property (writeBeats == 4'h8 || writeBeats == 4'hA)
        else $error("write burst length neither 8 nor 10");
    one_driver_a: assert property (!(ctlDqOe && devDqOe))
        else $error("both ends drive data");
    cover property (mrsOut && bank == 3'h1);
    cover property ($rose(outputsOff));
    cover property ($rose(writeMaskOn));
endmodule

/* dram_mode_register_features_bench.sv */
/* Bench: controller and device joined by the link, driven over Wishbone.
   Assumes package, interface, both ends and the checker are compiled first. */
`timescale 1ns/10ps
module dram_mode_register_features_bench
    import ddr_mode_pkg::*;
;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0, wbAck;
    logic [3:0] wbAdr = 4'h0, wbSel = 4'h0;
    logic [31:0] wbDatW = 32'h0, wbDatR;
    logic [1:0] tempStatus = 2'h0, driverImpedance, selfRefreshRange;
    logic tempCool = 1'b0, outputsOff, strobeTermOn, writeMaskOn, writeInvOn, readInvOn;
    logic tempReportOn, quarterRate, wrPreambleTwo, rdPreambleTwo, refreshDone;
    logic [DATA_W-1:0] readWord = 8'h00;
    logic [2:0] terminationSel;
    logic [5:0] readLatency, writeLatency;
    logic [3:0] writeBeats;
    int seed = 32834, errTotal = 0, nChecks = 0, refCount = 0;
    int cwlTab [7] = '{9, 10, 11, 12, 14, 16, 18};
    always #12.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (refreshDone === 1'b1) refCount++;
    ddr_mode_link ddr_mode_link_inst ();
    ddr_mode_ctrl ddr_mode_ctrl_inst (.clk_sys, .arst_n, .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
        .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatW),
        .wb_dat_o(wbDatR), .wb_ack_o(wbAck), .link(ddr_mode_link_inst));
    ddr_mode_device ddr_mode_device_inst (.link(ddr_mode_link_inst), .internalCmd(),
        .writeWord(), .writeWordValid(), .*);
    ddr_mode_assertions ddr_mode_assertions_inst (.ck(ddr_mode_link_inst.ck),
        .csN(ddr_mode_link_inst.csN), .cmd(ddr_mode_link_inst.cmd),
        .bank(ddr_mode_link_inst.bank), .addr(ddr_mode_link_inst.addr),
        .ctlDqOe(ddr_mode_link_inst.ctlDqOe), .devDqOe(ddr_mode_link_inst.devDqOe),
        .devDqsOe(ddr_mode_link_inst.devDqsOe), .*);
    task automatic stopTest();
        $display("checks %0d mismatches %0d", nChecks, errTotal);
        if (errTotal == 0 && nChecks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        nChecks++;
        if (got !== exp) begin
            errTotal++;
            $display("ERROR %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic guard(input string what, input int n, input int lim);
        if (n >= lim) begin
            errTotal++;
            $display("ERROR %s expected below %0d seen %0d", what, lim, n);
            stopTest();
        end
    endtask
    task automatic wbCycle(input logic we, input logic [3:0] adr, input logic [31:0] dat,
        output logic [31:0] rd);
        int n;
        @(posedge clk_sys);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbSel <= 4'hF;
        wbAdr <= adr;
        wbDatW <= dat;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (wbAck !== 1'b1 && n < 50);
        guard("ack wait", n, 50);
        rd = wbDatR;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
    endtask
    // Waits out busy, then lets the device's register update land
    task automatic linkCmd(input logic [2:0] c, input logic [2:0] b, input logic [13:0] v);
        logic [31:0] st;
        int n;
        wbCycle(1'b1, OFS_CMD, {12'h000, c, b, v}, st);
        n = 0;
        do begin
            wbCycle(1'b0, OFS_STATUS, 32'h0, st);
            n++;
        end while (st[8] !== 1'b0 && n < 40);
        guard("busy wait", n, 40);
        repeat (8) @(posedge clk_sys);
    endtask
    initial begin
        logic [13:0] v;
        logic [31:0] st;
        int a;
        repeat (5) @(posedge clk_sys);
        arst_n <= 1'b1;
        readWord <= $random(seed);
        tempStatus <= $random(seed);
        @(posedge clk_sys);
        check("writeBeats", 8, writeBeats);
        check("quarterRate", 0, quarterRate);
        for (int i = 0; i < 6; i++) begin
            v = $random(seed);
            v = (v & 14'h3FE7) | 14'h0001;
            linkCmd(CMD_MRS, 3'h1, v);
            check("driverImpedance", v[2:1], driverImpedance);
            check("outputsOff", v[12], outputsOff);
            check("strobeTermOn", 0, strobeTermOn);
        end
        $display("drive test done");
        for (int c = 0; c < 7; c++) begin
            a = c % 3;
            linkCmd(CMD_MRS, 3'h1, 14'h0301 | 14'(a << 3));
            linkCmd(CMD_MRS, 3'h2, 14'(c << 3) | 14'(c % 4 << 6) | 14'(c % 2 << 12));
            a = (a == 0) ? 0 : CL_BASE - a;
            check("readLatency", a + CL_BASE, readLatency);
            check("writeLatency", a + cwlTab[c], writeLatency);
            check("selfRefreshRange", c % 4, selfRefreshRange);
            check("writeBeats", c % 2 ? 10 : 8, writeBeats);
        end
        $display("latency test done");
        linkCmd(CMD_MRS, 3'h5, 14'h1D40);
        check("writeMaskOn", 1, writeMaskOn);
        check("writeInvOn", 0, writeInvOn);
        check("readInvOn", 1, readInvOn);
        check("parkSel", 5, terminationSel);
        wbCycle(1'b1, OFS_CFG, 32'h1, st);
        repeat (24) @(posedge clk_sys);
        check("nominalSel", 3, terminationSel);
        wbCycle(1'b1, OFS_CFG, 32'h0, st);
        wbCycle(1'b1, OFS_CMD, {12'h000, CMD_MRS, 3'h7, 14'h0000}, st);
        wbCycle(1'b0, OFS_STATUS, 32'h0, st);
        check("refused", 1, st[9]);
        wbCycle(1'b1, OFS_STATUS, 32'h200, st);
        wbCycle(1'b0, 4'hC, 32'h0, st);
        check("unmapped", 0, st);
        $display("termination test done");
        linkCmd(CMD_MRS, 3'h3, 14'h0030);
        check("tempReportOn", 1, tempReportOn);
        wbCycle(1'b1, OFS_CFG, 32'h2, st);
        linkCmd(CMD_MRS, 3'h4, 14'h1808);
        check("maskedPreamble", 0, wrPreambleTwo);
        wbCycle(1'b1, OFS_CFG, 32'h0, st);
        linkCmd(CMD_MRS, 3'h4, 14'h1808);
        check("wrPreambleTwo", 1, wrPreambleTwo);
        check("rdPreambleTwo", 1, rdPreambleTwo);
        $display("preamble test done");
        // CRC on as well, so later MR3 writes get their latency field
        linkCmd(CMD_MRS, 3'h2, 14'h10C8);
        tempCool <= 1'b1;
        refCount = 0;
        linkCmd(CMD_REF, 3'h0, 14'h0000);
        linkCmd(CMD_REF, 3'h0, 14'h0000);
        check("refreshes", 1, refCount);
        linkCmd(CMD_RD, 3'h0, 14'h0000);
        repeat (200) @(posedge clk_sys);
        wbCycle(1'b0, OFS_STATUS, 32'h0, st);
        check("readByte", readWord, st[7:0]);
        linkCmd(CMD_MRS, 3'h3, 14'h0006);
        wbCycle(1'b0, OFS_CMD, 32'h0, st);
        check("writeCmdLatency", 1, st[10:9]);
        linkCmd(CMD_RD, 3'h0, 14'h0000);
        repeat (200) @(posedge clk_sys);
        wbCycle(1'b0, OFS_STATUS, 32'h0, st);
        check("tempByte", {3'h0, tempStatus, 3'h0}, st[7:0]);
        $display("read test done");
        // Sync last: quarter rate may change command spacing
        linkCmd(CMD_MRS, 3'h3, 14'h0008);
        linkCmd(CMD_SYNC, 3'h0, 14'h0000);
        check("quarterRate", 1, quarterRate);
        $display("refresh and gear test done");
        stopTest();
    end
endmodule
